/* File: common/ssic_pkg.sv */
`default_nettype none
package ssic_pkg;
    // Address width of the 1M x 72 organisation
    localparam int ADDR_W = 20;
    // Eight byte lanes, each eight data bits and one check bit
    localparam int LANES = 8;
    localparam int LANE_W = 9;
    localparam int DATA_W = LANES * LANE_W;
    // Storage depth kept small so the model stays synthesizable
    localparam int MEM_AW = 4;
    localparam int MEM_DEPTH = 16;
    // Value of the burst order strap after reset (interleaved)
    localparam logic BURST_ORDER_RST = 1'b1;
    // Command captured from the pins at a recognised edge
    typedef enum logic [1:0] {
        SSIC_DESEL = 2'b00,
        SSIC_READ = 2'b01,
        SSIC_WRITE = 2'b10
    } ssic_cmd_e;
endpackage
`default_nettype wire

/* File: logic/ssic_lane_store.sv */
`timescale 1ns/1ps
`default_nettype none
// One entry-addressed store with per-lane write gating
module ssic_lane_store
    import ssic_pkg::*;
(
    input wire logic i_clock,
    input wire logic i_enable,
    input wire logic i_write,
    input wire logic [MEM_AW-1:0] i_index,
    input wire logic [LANES-1:0] i_lane_write,
    input wire logic [DATA_W-1:0] i_data,
    output logic [DATA_W-1:0] o_data
);
    // Each lane owns its storage, so no two lane processes share a variable
    for (genvar g = 0; g < LANES; g++) begin : g_lane
        logic [LANE_W-1:0] lane_q [MEM_DEPTH]; // This lane of every entry
        // Read port is combinational; the caller registers it
        assign o_data[g*LANE_W +: LANE_W] = lane_q[i_index];
        // The lane writes its byte and check bit only when its select is set
        always_ff @(posedge i_clock) begin
            if (i_enable && i_write && i_lane_write[g]) begin
                lane_q[i_index] <= i_data[g*LANE_W +: LANE_W];
            end
        end
    end
endmodule // ssic_lane_store
`default_nettype wire

/* File: logic/ssic_top.sv */
// How it works
// - Address captured at a recognised rising edge
// - Active-low lane selects gate byte and check
// - Write enable sampled only when clock gate low
// - Step high advances the burst counter
// - Step low loads a fresh start address
// - Edges with clock gate high are ignored
// - Select one is active low, sampled
// - Select two is active high, sampled
// - Select three is active low, sampled
// - Clock gate high freezes all state, no deselect
// - Strap picks interleaved or linear burst order
// - Outputs off on write data, deselect, first-after
`timescale 1ns/1ps
`default_nettype none
module ssic_top
    import ssic_pkg::*;
(
    input wire logic i_clock,
    input wire logic i_reset,
    input wire logic i_clock_gate_n,
    input wire logic [ADDR_W-1:0] i_addr,
    input wire logic [LANES-1:0] i_lane_write_select_n,
    input wire logic i_write_n,
    input wire logic i_burst_step_or_load,
    input wire logic i_select_low_one,
    input wire logic i_select_high_two,
    input wire logic i_select_low_three,
    input wire logic i_output_enable_n,
    input wire logic i_burst_order,
    input wire logic [DATA_W-1:0] i_data,
    output logic [DATA_W-1:0] o_data,
    output logic [DATA_W-1:0] o_data_oe,
    output logic [ADDR_W-1:0] o_access_addr,
    output logic o_selected
);
    // Clock gate is active low; every register holds while it is high
    logic enable;
    assign enable = !i_clock_gate_n;

    // All three selects must agree for the device to be selected
    logic select_now;
    assign select_now = !i_select_low_one && i_select_high_two
        && !i_select_low_three;

    // Registered command state
    ssic_cmd_e cmd_q, cmd_d;
    logic [ADDR_W-1:0] base_q, base_d; // Loaded start address
    logic [1:0] count_q, count_d; // Burst step count
    logic write_q, write_d; // Current burst is a write
    logic [LANES-1:0] lanes_q, lanes_d; // Registered active-high lane enables
    logic was_desel_q; // Previous recognised cycle deselected
    logic first_q; // First cycle after leaving deselect
    logic order_q; // Burst order strap captured while deselected
    logic [DATA_W-1:0] rdata_q; // Read data register

    // Burst low bits: linear adds, interleaved xors
    logic [1:0] low_bits;
    assign low_bits = order_q ? (base_q[1:0] ^ count_q)
        : 2'(base_q[1:0] + count_q);
    logic [ADDR_W-1:0] cur_addr;
    assign cur_addr = {base_q[ADDR_W-1:2], low_bits};

    // Next state: load on step low, advance on step high
    always_comb begin
        base_d = base_q;
        count_d = count_q;
        write_d = write_q;
        cmd_d = SSIC_DESEL;
        lanes_d = ~i_lane_write_select_n;
        if (!select_now && !i_burst_step_or_load) begin
            // Deselect only takes effect on a load cycle
            cmd_d = SSIC_DESEL;
        end else if (!i_burst_step_or_load) begin
            base_d = i_addr;
            count_d = 2'h0;
            write_d = !i_write_n;
            cmd_d = write_d ? SSIC_WRITE : SSIC_READ;
        end else if (cmd_q != SSIC_DESEL) begin
            count_d = 2'(count_q + 2'h1);
            cmd_d = write_q ? SSIC_WRITE : SSIC_READ;
        end
    end

    // Command registers, frozen while the clock gate is high
    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            cmd_q <= SSIC_DESEL;
            base_q <= '0;
            count_q <= 2'h0;
            write_q <= 1'b0;
            lanes_q <= '0;
            was_desel_q <= 1'b1;
            first_q <= 1'b0;
        end else if (enable) begin
            cmd_q <= cmd_d;
            base_q <= base_d;
            count_q <= count_d;
            write_q <= write_d;
            lanes_q <= lanes_d;
            was_desel_q <= (cmd_d == SSIC_DESEL);
            first_q <= was_desel_q && (cmd_d != SSIC_DESEL);
        end
    end

    // Strap is caught by a clocked process, never by the reset itself
    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            order_q <= BURST_ORDER_RST;
        end else if (enable && was_desel_q && cmd_q == SSIC_DESEL) begin
            order_q <= i_burst_order;
        end
    end

    // Store: write data arrives the cycle after its command
    logic [DATA_W-1:0] store_out;
    ssic_lane_store u_store (
        .i_clock(i_clock),
        .i_enable(enable),
        .i_write(cmd_q == SSIC_WRITE),
        .i_index(cur_addr[MEM_AW-1:0]),
        .i_lane_write(lanes_q),
        .i_data(i_data),
        .o_data(store_out)
    );

    // Read data register
    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            rdata_q <= '0;
        end else if (enable) begin
            rdata_q <= store_out;
        end
    end

    // Drive only for reads, never in write data, deselect or first cycle
    logic drive;
    assign drive = (cmd_q == SSIC_READ) && !first_q
        && !i_output_enable_n;
    assign o_data = rdata_q;
    assign o_data_oe = {DATA_W{drive}};
    assign o_access_addr = cur_addr;
    assign o_selected = (cmd_q != SSIC_DESEL);

    // Frozen edge keeps the command unchanged
    AST_FREEZE: assert property (@(posedge i_clock) disable iff (i_reset)
        i_clock_gate_n |=> $stable(cmd_q) && $stable(base_q))
        else $error("state moved while clock gate high");
    // Load edge with full select captures the address
    AST_LOAD: assert property (@(posedge i_clock) disable iff (i_reset)
        (enable && select_now && !i_burst_step_or_load) |=> base_q == $past(i_addr))
        else $error("address not loaded");
    // Bad select combination on a load deselects
    AST_DESEL: assert property (@(posedge i_clock) disable iff (i_reset)
        (enable && !select_now && !i_burst_step_or_load) |=> cmd_q == SSIC_DESEL)
        else $error("device not deselected");
    // Write enable low on a load makes a write
    AST_WRITE: assert property (@(posedge i_clock) disable iff (i_reset)
        (enable && select_now && !i_burst_step_or_load && !i_write_n)
        |=> cmd_q == SSIC_WRITE)
        else $error("write not started");
    // Advance steps the counter by one
    AST_STEP: assert property (@(posedge i_clock) disable iff (i_reset)
        (enable && i_burst_step_or_load && cmd_q != SSIC_DESEL)
        |=> count_q == 2'($past(count_q) + 2'h1))
        else $error("burst counter did not advance");
    // Outputs are off during deselect and write
    AST_HIZ: assert property (@(posedge i_clock) disable iff (i_reset)
        (cmd_q != SSIC_READ || first_q) |-> o_data_oe == '0)
        else $error("outputs driven when they must be off");
    // Lane enables follow inverted selects
    AST_LANES: assert property (@(posedge i_clock) disable iff (i_reset)
        enable |=> lanes_q == ~$past(i_lane_write_select_n))
        else $error("lane enables wrong");
    // Loaded access starts at its own address
    AST_ADDR: assert property (@(posedge i_clock) disable iff (i_reset)
        (enable && select_now && !i_burst_step_or_load) |=> o_access_addr == $past(i_addr))
        else $error("access address wrong");

    // Edge kinds seen at the pins, used to build the multi-step checks
    sequence s_desel_edge;
        enable && !select_now && !i_burst_step_or_load;
    endsequence
    sequence s_load_edge;
        enable && select_now && !i_burst_step_or_load;
    endsequence
    sequence s_read_load;
        enable && select_now && !i_burst_step_or_load && i_write_n;
    endsequence

    // Leaving deselect keeps the pins off for one clock
    AST_FIRST_OFF: assert property (@(posedge i_clock) disable iff (i_reset)
        s_desel_edge ##1 s_load_edge |=> o_data_oe == '0)
        else $error("outputs driven in first clock after deselect");
    // Back to back reads drive the pins when output enable allows
    AST_READ_ON: assert property (@(posedge i_clock) disable iff (i_reset)
        s_read_load ##1 s_read_load |=> i_output_enable_n || o_data_oe == '1)
        else $error("outputs off during a read data phase");
    // Write enable high on a load starts a read, never a write
    AST_NO_WRITE: assert property (@(posedge i_clock) disable iff (i_reset)
        s_read_load |=> cmd_q == SSIC_READ)
        else $error("write started with write enable high");
    // A load restarts the burst counter
    AST_COUNT_LOAD: assert property (@(posedge i_clock) disable iff (i_reset)
        s_load_edge |=> count_q == 2'h0)
        else $error("burst counter not cleared on load");
    // Step while deselected leaves the device deselected
    AST_STEP_IDLE: assert property (@(posedge i_clock) disable iff (i_reset)
        (enable && i_burst_step_or_load && cmd_q == SSIC_DESEL) |=> cmd_q == SSIC_DESEL)
        else $error("step while deselected started an access");
    // Gated edges leave data, access address and selected outputs as they were
    AST_FREEZE_OUT: assert property (@(posedge i_clock) disable iff (i_reset)
        i_clock_gate_n |=> $stable(o_data) && $stable(o_access_addr) && $stable(o_selected))
        else $error("outputs moved while clock gate high");
    // The strap is taken only while deselected
    AST_ORDER_HOLD: assert property (@(posedge i_clock) disable iff (i_reset)
        (cmd_q != SSIC_DESEL) |=> $stable(order_q))
        else $error("burst order changed during an access");
endmodule // ssic_top
`default_nettype wire

/* File: sim/ssic_ctrl_model.sv */
`timescale 1ns/1ps
`default_nettype none
// Memory controller model: drives every pin just after a rising edge
module ssic_ctrl_model
    import ssic_pkg::*;
(
    input wire logic i_clock,
    output logic o_gate_n,
    output logic [ADDR_W-1:0] o_addr,
    output logic [LANES-1:0] o_lanes_n,
    output logic o_write_n,
    output logic o_step,
    output logic [2:0] o_sel,
    output logic [DATA_W-1:0] o_data
);
    logic gate_req = 1'b0; // Clock gate for the next command
    logic wr_q = 1'b0; // Last taken command was a write
    logic [DATA_W-1:0] wd_q = '0; // Its data, sent one cycle later
    // Idle and deselected from time zero
    initial begin
        o_gate_n = 1'b0;
        o_addr = '0;
        o_lanes_n = '1;
        o_write_n = 1'b1;
        o_step = 1'b0;
        o_sel = 3'b100;
        o_data = '0;
    end
    // One command per edge; selects are {one, two, three}
    task automatic cmd(input logic [2:0] s, input logic w_n, input logic st,
            input logic [ADDR_W-1:0] a, input logic [LANES-1:0] ln,
            input logic [DATA_W-1:0] d);
        @(posedge i_clock);
        #2;
        o_gate_n = gate_req;
        o_sel = s;
        o_write_n = w_n;
        o_step = st;
        o_addr = a;
        o_lanes_n = ln;
        // Released bus toggles so a stale value never passes as data
        o_data = wr_q ? wd_q : ~o_data;
        // Gated edges are not taken, so the pending data stays put
        if (!gate_req) begin
            wr_q = !w_n && s == 3'b010;
            wd_q = d;
        end
    endtask
endmodule // ssic_ctrl_model
`default_nettype wire

/* File: sim/ssic_top_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module ssic_top_tb
    import ssic_pkg::*;
;
    localparam logic [DATA_W-1:0] V = {LANES{9'h15a}}; // First pattern
    localparam logic [DATA_W-1:0] W = {LANES{9'h0c3}}; // Second pattern
    logic i_clock = 1'b0;
    logic i_reset = 1'b1;
    logic gate_n, wr_n, step, sel_q;
    logic [2:0] sel;
    logic [ADDR_W-1:0] addr, acc;
    logic [LANES-1:0] ln;
    logic [DATA_W-1:0] di, dq, oe;
    int mismatches = 0;
    int n_compared = 0;
    logic oe_n = 1'b0; // Output enable, active low
    logic order = 1'b1; // Burst order strap, high for interleaved
    ssic_ctrl_model m (.i_clock(i_clock), .o_gate_n(gate_n), .o_addr(addr),
        .o_lanes_n(ln), .o_write_n(wr_n), .o_step(step), .o_sel(sel), .o_data(di));
    ssic_top uut (.i_clock(i_clock), .i_reset(i_reset), .i_clock_gate_n(gate_n),
        .i_addr(addr), .i_lane_write_select_n(ln), .i_write_n(wr_n),
        .i_burst_step_or_load(step), .i_select_low_one(sel[2]),
        .i_select_high_two(sel[1]), .i_select_low_three(sel[0]),
        .i_output_enable_n(oe_n), .i_burst_order(order), .i_data(di), .o_data(dq),
        .o_data_oe(oe), .o_access_addr(acc), .o_selected(sel_q));
    // Clock of 25 ns
    initial begin
        forever #12.5 i_clock = ~i_clock;
    end
    // One compare for every kind of result, widened to the data width
    task automatic chk(input string nm, input logic [DATA_W-1:0] e, input logic [DATA_W-1:0] g);
        n_compared++;
        if (g !== e) begin
            mismatches++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic idle();
        m.cmd(3'b100, 1'b1, 1'b0, '0, '1, '0);
    endtask
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [LANES-1:0] l,
            input logic [DATA_W-1:0] d);
        m.cmd(3'b010, 1'b0, 1'b0, a, l, d);
        idle();
    endtask
    // Three reads back to back: first clock blanked, then data, then enable and deselect off
    task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
        repeat (2) m.cmd(3'b010, 1'b1, 1'b0, a, '1, '0);
        chk("oe", '0, oe);
        m.cmd(3'b010, 1'b1, 1'b0, a, '1, '0);
        chk("rdata", e, dq);
        chk("oe", '1, oe);
        oe_n = 1'b1;
        idle();
        chk("oe", '0, oe);
        oe_n = 1'b0;
        idle();
        chk("oe", '0, oe);
    endtask
    // Gated edges take neither the write nor anything else
    task automatic t_gate();
        wr(20'h3, '0, V);
        m.gate_req = 1'b1;
        wr(20'h3, '0, W);
        m.gate_req = 1'b0;
        rd_chk(20'h3, V);
    endtask
    // Only the lanes selected low are written, check bits included
    task automatic t_lanes();
        wr(20'h3, 8'hf0, W);
        rd_chk(20'h3, {V[71:36], W[35:0]});
    endtask
    // Load 5 then step: interleaved order gives 4, linear gives 6
    task automatic t_burst(input logic o, input logic [ADDR_W-1:0] e);
        order = o;
        repeat (2) idle();
        m.cmd(3'b010, 1'b1, 1'b0, 20'h5, '1, '0);
        m.cmd(3'b010, 1'b1, 1'b1, 20'h9, '1, '0);
        chk("addr", DATA_W'(20'h5), DATA_W'(acc));
        idle();
        chk("addr", DATA_W'(e), DATA_W'(acc));
        // Step while deselected is ignored
        m.cmd(3'b010, 1'b1, 1'b1, 20'h9, '1, '0);
        idle();
        chk("selected", '0, DATA_W'(sel_q));
        chk("addr", DATA_W'(e), DATA_W'(acc));
    endtask
    // Mid-run reset clears command, address and read data
    task automatic t_reset();
        i_reset = 1'b1;
        idle();
        i_reset = 1'b0;
        chk("selected", '0, DATA_W'(sel_q));
        chk("addr", '0, DATA_W'(acc));
        chk("rdata", '0, dq);
        chk("oe", '0, oe);
    endtask
    // Every select combination; only low, high, low selects
    task automatic t_sel();
        for (int s = 0; s < 8; s++) begin
            m.cmd(3'(s), 1'b1, 1'b0, 20'h1, '1, '0);
            idle();
            chk("selected", DATA_W'(s == 2), DATA_W'(sel_q));
        end
        idle();
        chk("oe", '0, oe);
    endtask
    task automatic finish_test();
        $display("Compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // Main sequence
    initial begin
        repeat (16) @(posedge i_clock);
        #2;
        i_reset = 1'b0;
        t_gate();
        t_lanes();
        t_burst(1'b1, 20'h4);
        t_burst(1'b0, 20'h6);
        t_reset();
        t_sel();
        finish_test();
    end
endmodule // ssic_top_tb
`default_nettype wire
